// File: verilog/aft_pkg.sv
// constants and types for the antialias filter tuning control
package aft_pkg;

    // register addresses on the serial configuration port
    localparam logic [7:0] ADDR_RESP_CODE = 8'h1c;
    localparam logic [7:0] ADDR_NEG_STAT  = 8'h1d;
    localparam logic [7:0] ADDR_NEG_CAP   = 8'h1e;
    localparam logic [7:0] ADDR_POS_STAT  = 8'h1f;

    // field positions
    localparam int ERR_BIT    = 5;
    localparam int BUSY_BIT   = 0;
    localparam int LOCKED_BIT = 1;
    localparam int CAP_W      = 5;

    // reset values and the unmapped read value
    localparam logic [7:0]       RESP_CODE_RST = 8'h00;
    localparam logic [CAP_W-1:0] CAP_RST       = 5'h00;
    localparam logic [7:0]       UNMAPPED_READ = 8'h00;

    // code that arms the write lockout
    localparam logic [7:0] RESP_LOCK_CODE = 8'h00;

    // measurement window: a time, and the cycle count derived from it
    localparam int CLK_PERIOD_NS  = 40;
    localparam int MEAS_TIME_NS   = 40960;
    localparam int MEAS_CYCLES    = MEAS_TIME_NS / CLK_PERIOD_NS;
    localparam int WIN_W          = 11;
    localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(MEAS_CYCLES - 1);

    // oscillator edge counter and product widths
    localparam int CNT_W  = 12;
    localparam int PROD_W = CNT_W + 8;

    // scaling of (oscillator count x response code) into each capacitor code
    localparam int NEG_SHIFT = 11;
    localparam int POS_SHIFT = 12;
    localparam logic [PROD_W-1:0] CAP_MAX_VAL = PROD_W'(31);
    localparam logic [PROD_W-1:0] CAP_MIN_VAL = PROD_W'(1);
    localparam logic [CAP_W-1:0]  CAP_TOP     = 5'h1f;
    localparam logic [CAP_W-1:0]  CAP_BOTTOM  = 5'h00;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MEASURE,
        ST_LOAD
    } aft_state_t;

    typedef struct packed {
        aft_state_t        state;
        logic [7:0]        resp_code;
        logic              locked;
        logic [WIN_W-1:0]  win_cnt;
        logic [CNT_W-1:0]  osc_cnt;
        logic              osc_prev;
        logic [CAP_W-1:0]  neg_cap;
        logic              neg_err;
        logic [CAP_W-1:0]  pos_cap;
        logic              pos_err;
        logic              done;
        logic [7:0]        rdata;
    } aft_regs_t;

    localparam aft_regs_t REGS_RST = '0;

endpackage : aft_pkg

// File: verilog/aft_tuning_control.sv
// start-up tuning control of the antialias filter capacitor arrays
//
// How it works
// R1: writing the response code starts tuning
// R2: count oscillator edges over clock window
// R3: compute and load both capacitor codes
// R4: clamp unreachable code, set side error
// R5: writing zero locks response register until power-off
// R6: response register resets to zero
// R7: code 0x60 gives cutoff clock/3.2
// R8: cutoff scales inversely with response code
// R9: host should put converter in standby first
// R10: under 10% error from 13 to 18 MHz
// R11: host should tune during start-up
// R12: each run clears both error flags first
`timescale 1ns/10ps

module aft_tuning_control (
    input  wire logic       core_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       rc_osc_i,
    output logic      [4:0] neg_side_cap_code_o,
    output logic      [4:0] pos_side_cap_code_o,
    output logic            neg_side_range_error_o,
    output logic            pos_side_range_error_o,
    output logic            tune_busy_o,
    output logic            tune_done_o,
    output logic            resp_locked_o
);

    aft_pkg::aft_regs_t r;
    aft_pkg::aft_regs_t next_r;

    logic                       wr_resp;
    logic [aft_pkg::PROD_W-1:0] prod;
    logic                       osc_rise;

    // map a scaled product onto the capacitor range, flagging clamps
    function automatic logic [aft_pkg::CAP_W:0] fit_cap(
        input logic [aft_pkg::PROD_W-1:0] v
    );
        logic [aft_pkg::CAP_W:0] res;
        res = {1'b0, aft_pkg::CAP_BOTTOM};
        if (v > aft_pkg::CAP_MAX_VAL) begin
            res = {1'b1, aft_pkg::CAP_TOP};          // see R4
        end else if (v < aft_pkg::CAP_MIN_VAL) begin
            res = {1'b1, aft_pkg::CAP_BOTTOM};       // see R4
        end else begin
            res = {1'b0, v[aft_pkg::CAP_W-1:0]};
        end
        return res;
    endfunction : fit_cap

    // a run is under way while measuring or loading
    function automatic logic run_active(
        input aft_pkg::aft_state_t st
    );
        logic act;
        act = 1'b0;
        if (st != aft_pkg::ST_IDLE) begin
            act = 1'b1;
        end
        return act;
    endfunction : run_active

    // rising edge of the oscillator between two samples
    function automatic logic osc_rising(
        input logic level,
        input logic prev
    );
        return level && !prev;
    endfunction : osc_rising

    // count one oscillator edge, holding at full scale
    function automatic logic [aft_pkg::CNT_W-1:0] sat_inc(
        input logic [aft_pkg::CNT_W-1:0] c
    );
        logic [aft_pkg::CNT_W-1:0] n;
        n = c;
        if (c != '1) begin
            n = c + 1'b1;
        end
        return n;
    endfunction : sat_inc

    // last converter clock of the fixed measurement window
    function automatic logic window_end(
        input logic [aft_pkg::WIN_W-1:0] w
    );
        return (w == aft_pkg::WIN_LAST);                             // see R10
    endfunction : window_end

    // oscillator edge count times response code
    function automatic logic [aft_pkg::PROD_W-1:0] rate_times_code(
        input logic [aft_pkg::CNT_W-1:0] cnt,
        input logic [7:0]                code
    );
        logic [aft_pkg::PROD_W-1:0] p;
        p = aft_pkg::PROD_W'(cnt) * aft_pkg::PROD_W'(code);
        return p;
    endfunction : rate_times_code

    // scale the product for one side and fit it to its range
    function automatic logic [aft_pkg::CAP_W:0] side_code(
        input logic [aft_pkg::PROD_W-1:0] p,
        input int                         shift
    );
        logic [aft_pkg::PROD_W-1:0] scaled;
        scaled = p >> shift;
        return fit_cap(scaled);
    endfunction : side_code

    // negative side status: range error, busy and lockout
    function automatic logic [7:0] neg_status(
        input aft_pkg::aft_regs_t s
    );
        logic [7:0] d;
        d                      = aft_pkg::UNMAPPED_READ;
        d[aft_pkg::ERR_BIT]    = s.neg_err;
        d[aft_pkg::BUSY_BIT]   = run_active(s.state);
        d[aft_pkg::LOCKED_BIT] = s.locked;
        return d;
    endfunction : neg_status

    // positive side status: range error beside its code
    function automatic logic [7:0] pos_status(
        input aft_pkg::aft_regs_t s
    );
        logic [7:0] d;
        d                     = aft_pkg::UNMAPPED_READ;
        d[aft_pkg::ERR_BIT]   = s.pos_err;
        d[aft_pkg::CAP_W-1:0] = s.pos_cap;
        return d;
    endfunction : pos_status

    // a capacitor code in the low bits of a register byte
    function automatic logic [7:0] cap_byte(
        input logic [aft_pkg::CAP_W-1:0] c
    );
        logic [7:0] d;
        d                     = aft_pkg::UNMAPPED_READ;
        d[aft_pkg::CAP_W-1:0] = c;
        return d;
    endfunction : cap_byte

    // one converter clock of the measurement window
    function automatic aft_pkg::aft_regs_t measure_step(
        input aft_pkg::aft_regs_t s,
        input logic               rise
    );
        aft_pkg::aft_regs_t n;
        n         = s;
        n.win_cnt = s.win_cnt + 1'b1;                                // see R2
        if (rise) begin
            n.osc_cnt = sat_inc(s.osc_cnt);                          // see R2
        end
        if (window_end(s.win_cnt)) begin
            n.state = aft_pkg::ST_LOAD;
        end
        return n;
    endfunction : measure_step

    // load both capacitor codes from the finished measurement
    function automatic aft_pkg::aft_regs_t load_codes(
        input aft_pkg::aft_regs_t         s,
        input logic [aft_pkg::PROD_W-1:0] p
    );
        aft_pkg::aft_regs_t n;
        n                      = s;
        {n.neg_err, n.neg_cap} = side_code(p, aft_pkg::NEG_SHIFT);   // see R3 R4
        {n.pos_err, n.pos_cap} = side_code(p, aft_pkg::POS_SHIFT);   // see R3 R4
        n.state                = aft_pkg::ST_IDLE;
        n.done                 = 1'b1;
        return n;
    endfunction : load_codes

    // accepted write: take the code, arm lockout on zero, restart
    function automatic aft_pkg::aft_regs_t begin_run(
        input aft_pkg::aft_regs_t s,
        input logic [7:0]         code
    );
        aft_pkg::aft_regs_t n;
        n           = s;
        n.resp_code = code;
        if (code == aft_pkg::RESP_LOCK_CODE) begin
            n.locked = 1'b1;                                         // see R5
        end
        n.state   = aft_pkg::ST_MEASURE;                             // see R1
        n.win_cnt = '0;
        n.osc_cnt = '0;
        n.neg_err = 1'b0;                                            // see R12
        n.pos_err = 1'b0;                                            // see R12
        n.done    = 1'b0;
        return n;
    endfunction : begin_run

    // a write reaches the response register only while unlocked
    function automatic logic resp_write(
        input logic       wr,
        input logic [7:0] addr,
        input logic       locked
    );
        logic hit;
        hit = 1'b0;
        if (wr && (addr == aft_pkg::ADDR_RESP_CODE) && !locked) begin // see R5
            hit = 1'b1;
        end
        return hit;
    endfunction : resp_write

    // idle: the window counter rests at zero until a write arrives
    function automatic aft_pkg::aft_regs_t idle_step(
        input aft_pkg::aft_regs_t s
    );
        aft_pkg::aft_regs_t n;
        n         = s;
        n.win_cnt = '0;
        return n;
    endfunction : idle_step

    // read data for one register address
    function automatic logic [7:0] read_mux(
        input logic [7:0]               addr,
        input aft_pkg::aft_regs_t       s
    );
        logic [7:0] d;
        d = aft_pkg::UNMAPPED_READ;
        if (addr == aft_pkg::ADDR_RESP_CODE) begin
            d = s.resp_code;
        end else if (addr == aft_pkg::ADDR_NEG_STAT) begin
            d = neg_status(s);
        end else if (addr == aft_pkg::ADDR_NEG_CAP) begin
            d = cap_byte(s.neg_cap);
        end else if (addr == aft_pkg::ADDR_POS_STAT) begin
            d = pos_status(s);
        end
        return d;
    endfunction : read_mux

    // lockout gates every write to the response register
    assign wr_resp  = resp_write(reg_wr_i, reg_addr_i, r.locked);    // see R5
    assign osc_rise = osc_rising(rc_osc_i, r.osc_prev);
    // required capacitance follows oscillator rate times response code;
    // the side shifts scale code 0x60 to the clock/3.2 cutoff
    assign prod     = rate_times_code(r.osc_cnt, r.resp_code);       // see R7 R8

    always_comb begin
        next_r          = r;
        next_r.osc_prev = rc_osc_i;
        next_r.done     = 1'b0;

        // a read in the same clock as a write returns the old value
        if (reg_rd_i) begin
            next_r.rdata = read_mux(reg_addr_i, r);
        end

        case (r.state)
            aft_pkg::ST_IDLE: begin
                next_r = idle_step(next_r);
            end
            aft_pkg::ST_MEASURE: begin
                // oscillator edges per fixed span of converter clock
                next_r = measure_step(next_r, osc_rise);             // see R2 R10
            end
            aft_pkg::ST_LOAD: begin
                next_r = load_codes(next_r, prod);                   // see R3
            end
            default: begin
                next_r.state = aft_pkg::ST_IDLE;
            end
        endcase

        // a new accepted write restarts tuning, even mid-run
        if (wr_resp) begin
            next_r = begin_run(next_r, reg_wdata_i);                 // see R1 R5 R12
        end
    end

    // power-on reset clears the response code and the lockout;
    // a low clock enable freezes every register, read data and the
    // done pulse included, so the host may stretch a run
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= aft_pkg::REGS_RST;                                  // see R6
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    assign reg_rdata_o            = r.rdata;
    assign neg_side_cap_code_o    = r.neg_cap;
    assign pos_side_cap_code_o    = r.pos_cap;
    assign neg_side_range_error_o = r.neg_err;
    assign pos_side_range_error_o = r.pos_err;
    assign tune_busy_o            = run_active(r.state);
    assign tune_done_o            = r.done;
    assign resp_locked_o          = r.locked;

endmodule : aft_tuning_control

// File: testbench/aft_tuning_props.sv
// port assertions for the filter tuning control
`timescale 1ns/10ps
module aft_tuning_props (
    input wire logic       core_clk_i,
    input wire logic       nrst_i,
    input wire logic       ce_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       tune_busy_o,
    input wire logic       tune_done_o,
    input wire logic       resp_locked_o,
    input wire logic       neg_side_range_error_o,
    input wire logic       pos_side_range_error_o,
    input wire logic [4:0] neg_side_cap_code_o,
    input wire logic [4:0] pos_side_cap_code_o
);
    logic [11:0] run_cnt;
    wire start = ce_i && reg_wr_i && reg_addr_i == 8'h1c && !resp_locked_o;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_start; start; endsequence
    sequence s_clear; !neg_side_range_error_o && !pos_side_range_error_o; endsequence
    // enabled busy cycles since the last accepted run start
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) run_cnt <= 12'h000;
        else if (start) run_cnt <= 12'h001;
        else if (ce_i && tune_busy_o) run_cnt <= run_cnt + 12'h001;
    end
    chk_run_start: assert property (s_start |=> tune_busy_o ##0 s_clear)
        else $error("run start wrong");
    chk_done_time: assert property (tune_done_o |-> run_cnt == 12'h402 && !tune_busy_o)
        else $error("done at wrong cycle");
    chk_lock_arm: assert property (start && reg_wdata_i == 8'h00 |=> resp_locked_o)
        else $error("lock not armed");
    chk_lock_hold: assert property (resp_locked_o |=> resp_locked_o)
        else $error("lock dropped");
    chk_lock_deaf: assert property (resp_locked_o && !tune_busy_o |=> !tune_busy_o)
        else $error("run while locked");
    chk_neg_clamp: assert property (neg_side_range_error_o |->
        neg_side_cap_code_o inside {5'h00, 5'h1f}) else $error("neg not clamped");
    chk_pos_clamp: assert property (pos_side_range_error_o |->
        pos_side_cap_code_o inside {5'h00, 5'h1f}) else $error("pos not clamped");
    chk_code_load: assert property ($changed(neg_side_cap_code_o) ||
        $changed(pos_side_cap_code_o) |-> tune_done_o) else $error("code moved off load");
endmodule : aft_tuning_props
bind aft_tuning_control aft_tuning_props u_props (
    .core_clk_i             (core_clk_i),
    .nrst_i                 (nrst_i),
    .ce_i                   (ce_i),
    .reg_wr_i               (reg_wr_i),
    .reg_addr_i             (reg_addr_i),
    .reg_wdata_i            (reg_wdata_i),
    .tune_busy_o            (tune_busy_o),
    .tune_done_o            (tune_done_o),
    .resp_locked_o          (resp_locked_o),
    .neg_side_range_error_o (neg_side_range_error_o),
    .pos_side_range_error_o (pos_side_range_error_o),
    .neg_side_cap_code_o    (neg_side_cap_code_o),
    .pos_side_cap_code_o    (pos_side_cap_code_o)
);

// File: testbench/aft_osc_model.sv
// stand-in for the on-chip rc oscillator, parked low when half_i is zero
`timescale 1ns/10ps
module aft_osc_model (
    input  wire logic       core_clk_i,
    input  wire logic [1:0] half_i,
    output logic            rc_osc_o
);
    logic [1:0] cnt = 2'h0;
    initial rc_osc_o = 1'b0;
    always @(posedge core_clk_i) begin
        cnt <= (half_i == 2'h0 || cnt + 2'h1 >= half_i) ? 2'h0 : cnt + 2'h1;
        if (half_i == 2'h0) rc_osc_o <= 1'b0;
        else if (cnt + 2'h1 >= half_i) rc_osc_o <= !rc_osc_o;
    end
endmodule : aft_osc_model

// File: testbench/aft_tuning_control_test.sv
// self-checking bench for the filter tuning control
`timescale 1ns/10ps
module aft_tuning_control_test;
    logic core_clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic [4:0] neg_side_cap_code_o, pos_side_cap_code_o;
    logic rc_osc_i, neg_side_range_error_o, pos_side_range_error_o;
    logic tune_busy_o, tune_done_o, resp_locked_o;
    logic [1:0] half = 2'h0;
    int num_errors = 0, cmp_count = 0;
    aft_osc_model osc (.core_clk_i(core_clk_i), .half_i(half), .rc_osc_o(rc_osc_i));
    aft_tuning_control uut (
        .core_clk_i             (core_clk_i),
        .nrst_i                 (nrst_i),
        .ce_i                   (ce_i),
        .reg_wr_i               (reg_wr_i),
        .reg_rd_i               (reg_rd_i),
        .reg_addr_i             (reg_addr_i),
        .reg_wdata_i            (reg_wdata_i),
        .reg_rdata_o            (reg_rdata_o),
        .rc_osc_i               (rc_osc_i),
        .neg_side_cap_code_o    (neg_side_cap_code_o),
        .pos_side_cap_code_o    (pos_side_cap_code_o),
        .neg_side_range_error_o (neg_side_range_error_o),
        .pos_side_range_error_o (pos_side_range_error_o),
        .tune_busy_o            (tune_busy_o),
        .tune_done_o            (tune_done_o),
        .resp_locked_o          (resp_locked_o)
    );
    initial forever #20 core_clk_i = !core_clk_i;
    task automatic check(input string what, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= w;
        reg_rd_i <= !w;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1;
    endtask : acc
    task automatic rd(input logic [7:0] a, exp);
        acc(1'b0, a, 8'h00);
        check("register read", reg_rdata_o, exp);
    endtask : rd
    task automatic tune(input logic [7:0] code, input logic [4:0] n, p, input logic ne, pe, lk);
        acc(1'b1, 8'h1c, code);
        check("busy and flags", {5'h00, tune_busy_o, neg_side_range_error_o,
            pos_side_range_error_o}, 8'h04);
        repeat (1025) @(posedge core_clk_i);
        #1 check("done", {7'h00, tune_done_o}, 8'h01);
        rd(8'h1d, {2'h0, ne, 3'h0, lk, 1'b0});
        rd(8'h1e, {3'h0, n});
        rd(8'h1f, {2'h0, pe, p});
    endtask : tune
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    initial begin
        #400us;
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        ce_i <= 1'b0;
        acc(1'b1, 8'h1c, 8'h61);
        check("busy while frozen", {7'h00, tune_busy_o}, 8'h00);
        @(posedge core_clk_i);
        ce_i <= 1'b1;
        rd(8'h1c, 8'h00);
        rd(8'h1e, 8'h00);
        rd(8'h55, 8'h00);
        half <= 2'h2;
        tune(8'h61, 5'h0c, 5'h06, 1'b0, 1'b0, 1'b0);
        tune(8'h60, 5'h0c, 5'h06, 1'b0, 1'b0, 1'b0);
        half <= 2'h1;
        tune(8'hff, 5'h1f, 5'h1f, 1'b1, 1'b0, 1'b0);
        half <= 2'h0;
        tune(8'h61, 5'h00, 5'h00, 1'b1, 1'b1, 1'b0);
        tune(8'h00, 5'h00, 5'h00, 1'b1, 1'b1, 1'b1);
        acc(1'b1, 8'h1c, 8'h61);
        check("busy when locked", {7'h00, tune_busy_o}, 8'h00);
        rd(8'h1c, 8'h00);
        @(posedge core_clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        acc(1'b1, 8'h1c, 8'h61);
        check("lock and busy after power cycle", {6'h00, resp_locked_o, tune_busy_o}, 8'h01);
        print_verdict();
    end
endmodule : aft_tuning_control_test
